// ### rtl/aux_bus_pkg.sv
// Constants and types shared by the auxiliary sensor bus master.
package aux_bus_pkg;
   // -----------------------------------------------------------------
   // Primary bus target address
   // -----------------------------------------------------------------
   localparam logic [5:0] HOST_ADDR_HI   = 6'h1a;
   // -----------------------------------------------------------------
   // Channel and buffer sizes
   // -----------------------------------------------------------------
   localparam int         NUM_BURST_CH   = 4;
   localparam int         SENS_BYTES     = 24;
   localparam int         FIFO_WIDTH     = 8;
   localparam int         FIFO_DEPTH     = 8;
   localparam logic [2:0] SINGLE_CH      = 3'h4;
   localparam logic [4:0] SENS_BYTES_5   = 5'h18;
   // -----------------------------------------------------------------
   // Auxiliary bus bit timing on the link clock
   // -----------------------------------------------------------------
   localparam int         LINK_PERIOD_NS = 125;
   localparam int         AUX_QUARTER_NS = 625;
   localparam int         AUX_QUARTER_CYC_INT =
      (AUX_QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam logic [3:0] AUX_QUARTER_CYC = 4'(AUX_QUARTER_CYC_INT);
   // -----------------------------------------------------------------
   // Sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {C_IDLE, C_ISSUE, C_WAIT} core_st_t;
   typedef enum logic [2:0] {L_IDLE, L_START, L_BIT, L_ACK, L_RSTART, L_STOP, L_HSHK} link_st_t;
   typedef enum logic [2:0] {S_ADDR_W, S_REG, S_WDATA, S_ADDR_R, S_READ} step_t;
endpackage

// ### rtl/two_flop_sync.sv
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/100ps
module two_flop_sync
   import aux_bus_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d_i;
      st_nxt.s2 = st_r.s1;
      if (!rstn_i) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   assign q_o = st_r.s2;
endmodule

// ### rtl/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module byte_fifo
   import aux_bus_pkg::*;
#(
   parameter int W = FIFO_WIDTH,
   parameter int D = FIFO_DEPTH
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic        push;
   logic        pop;

   assign in_ready_o  = (st_r.cnt != (AW+1)'(D));
   assign out_valid_o = (st_r.cnt != '0);
   assign out_data_o  = st_r.mem[st_r.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data_i;
         st_nxt.wp           = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (!rstn_i) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end
endmodule

// ### rtl/aux_sensor_bus_master.sv
// Auxiliary sensor bus master with pass-through switch control.
//
// What this block does
// - On the primary bus the device only answers as a target and never starts a transfer.
// - The lowest bit of the primary target address follows the sampled address-select pin.
// - The auxiliary bus runs either as a master driven by the device or in pass-through.
// - In master mode the device fetches sensor data on its own for the motion coprocessor.
// - Burst reads total at most 24 bytes over at most 4 channels.
// - A fifth channel performs only single-byte reads or writes.
// - Pass-through disables the master logic and closes the switches onto the host bus.
// - In pass-through the host still reaches the device registers on the primary bus.
// - With the four-wire host interface selected the pass-through path is unavailable.
// - Channels 0 to 4 may address any target and register on the auxiliary bus.
// - Channel 4 never performs a multi-byte burst.
// - After configuration the master reads one or more bytes as each channel says.
// - Bytes read by channels 0 to 3 land in the sensor data store and optionally the FIFO.
// - A missing acknowledge from a sensor raises a status flag.
// - Lost arbitration, missing acknowledge and channel 4 completion are event sources.
`timescale 1ns/100ps
module aux_sensor_bus_master
   import aux_bus_pkg::*;
(
   input  wire logic                        core_clk_i,
   input  wire logic                        rstn_i,
   input  wire logic                        aux_link_clk_i,
   input  wire logic                        address_select_pin_i,
   input  wire logic                        spi_select_i,
   input  wire logic                        pass_through_i,
   input  wire logic                        master_en_i,
   input  wire logic                        sample_tick_i,
   input  wire logic [NUM_BURST_CH-1:0]     ch_en_i,
   input  wire logic [NUM_BURST_CH-1:0]     ch_fifo_en_i,
   input  wire logic [NUM_BURST_CH*7-1:0]   ch_addr_i,
   input  wire logic [NUM_BURST_CH*8-1:0]   ch_reg_i,
   input  wire logic [NUM_BURST_CH*4-1:0]   ch_len_i,
   input  wire logic                        ch4_start_i,
   input  wire logic                        ch4_rnw_i,
   input  wire logic [6:0]                  ch4_addr_i,
   input  wire logic [7:0]                  ch4_reg_i,
   input  wire logic [7:0]                  ch4_wdata_i,
   input  wire logic [2:0]                  flag_clr_i,
   output logic [6:0]                       host_target_addr_o,
   output logic                             bypass_switch_en_o,
   output logic [SENS_BYTES*8-1:0]          ext_sens_data_o,
   output logic [7:0]                       ch4_rdata_o,
   output logic                             nack_flag_o,
   output logic                             arb_lost_flag_o,
   output logic                             ch4_done_flag_o,
   output logic                             busy_o,
   output logic [FIFO_WIDTH-1:0]            fifo_data_o,
   output logic                             fifo_valid_o,
   input  wire logic                        fifo_ready_i,
   input  wire logic                        aux_serial_clock_i,
   output logic                             aux_serial_clock_o,
   output logic                             aux_serial_clock_oe_o,
   input  wire logic                        aux_serial_data_i,
   output logic                             aux_serial_data_o,
   output logic                             aux_serial_data_oe_o
);
   // ---------------------------------------------------------------
   // Core domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      core_st_t                 st;
      logic [2:0]               ch;
      logic [4:0]               idx;
      logic                     round;
      logic                     ch4_pend;
      logic [6:0]               cmd_addr;
      logic [7:0]               cmd_reg;
      logic                     cmd_rnw;
      logic [4:0]               cmd_len;
      logic [7:0]               cmd_wdata;
      logic                     cmd_fifo;
      logic                     cmd_tgl;
      logic                     ack_tgl;
      logic                     done_seen;
      logic [SENS_BYTES*8-1:0]  sens;
      logic [7:0]               ch4_rdata;
      logic                     nack_f;
      logic                     arb_f;
      logic                     ch4_f;
      logic                     ad0;
   } core_state_t;

   // ---------------------------------------------------------------
   // Link domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      link_st_t    st;
      step_t       step;
      logic [3:0]  tmr;
      logic [1:0]  q;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic [4:0]  left;
      logic [6:0]  addr;
      logic [7:0]  regn;
      logic        rnw;
      logic [7:0]  wdata;
      logic        cmd_seen;
      logic        scl_oe;
      logic        sda_oe;
      logic        nack;
      logic        arb;
      logic        req_tgl;
      logic        done_tgl;
      logic [7:0]  rbyte;
   } link_state_t;

   core_state_t c_r;
   core_state_t c_nxt;
   link_state_t l_r;
   link_state_t l_nxt;

   logic        ad0_s;
   logic [1:0]  from_link_s;
   logic [4:0]  to_link_s;
   logic        link_rstn;
   logic        fifo_in_ready;
   logic        fifo_push;
   logic [7:0]  push_data;
   logic [4:0]  room;
   logic [4:0]  want;
   logic        tick;
   logic        tx_bit;

   // ---------------------------------------------------------------
   // Crossings and the sensor byte FIFO
   // ---------------------------------------------------------------
   two_flop_sync #(.W(1)) u_ad0_sync (
      .clk_i  (core_clk_i),
      .rstn_i (rstn_i),
      .d_i    (address_select_pin_i),
      .q_o    (ad0_s)
   );

   two_flop_sync #(.W(2)) u_to_core_sync (
      .clk_i  (core_clk_i),
      .rstn_i (rstn_i),
      .d_i    ({l_r.req_tgl, l_r.done_tgl}),
      .q_o    (from_link_s)
   );

   two_flop_sync #(.W(1)) u_link_rst_sync (
      .clk_i  (aux_link_clk_i),
      .rstn_i (1'b1),
      .d_i    (rstn_i),
      .q_o    (link_rstn)
   );

   two_flop_sync #(.W(5)) u_to_link_sync (
      .clk_i  (aux_link_clk_i),
      .rstn_i (link_rstn),
      .d_i    ({aux_serial_data_i, aux_serial_clock_i, c_r.cmd_tgl, c_r.ack_tgl,
                pass_through_i}),
      .q_o    (to_link_s)
   );

   byte_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
      .clk_i       (core_clk_i),
      .rstn_i      (rstn_i),
      .in_data_i   (push_data),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_data_o),
      .out_valid_o (fifo_valid_o),
      .out_ready_i (fifo_ready_i)
   );

   // ---------------------------------------------------------------
   // Core sequencer
   // ---------------------------------------------------------------
   assign room      = SENS_BYTES_5 - c_r.idx;
   assign want      = (c_r.ch < SINGLE_CH) ? {1'b0, ch_len_i[c_r.ch[1:0]*4 +: 4]} : 5'h0;
   assign push_data = l_r.rbyte;

   always_comb begin
      c_nxt     = c_r;
      fifo_push = 1'b0;
      c_nxt.ad0 = ad0_s;
      if (sample_tick_i && master_en_i && !pass_through_i) begin
         c_nxt.round = 1'b1;
      end
      if (ch4_start_i) begin
         c_nxt.ch4_pend = 1'b1;
      end
      case (c_r.st)
         C_IDLE: begin
            c_nxt.ch = 3'h0;
            c_nxt.idx = 5'h0;
            if (!pass_through_i && c_r.round) begin
               c_nxt.round = 1'b0;
               c_nxt.st = C_ISSUE;
            end else if (!pass_through_i && c_r.ch4_pend) begin
               c_nxt.ch = SINGLE_CH;
               c_nxt.st = C_ISSUE;
            end
         end
         C_ISSUE: begin
            if (c_r.ch == SINGLE_CH && c_r.ch4_pend) begin
               c_nxt.cmd_addr  = ch4_addr_i;
               c_nxt.cmd_reg   = ch4_reg_i;
               c_nxt.cmd_rnw   = ch4_rnw_i;
               c_nxt.cmd_len   = 5'h1;
               c_nxt.cmd_wdata = ch4_wdata_i;
               c_nxt.cmd_fifo  = 1'b0;
               c_nxt.ch4_pend  = ch4_start_i;
               c_nxt.cmd_tgl   = ~c_r.cmd_tgl;
               c_nxt.st        = C_WAIT;
            end else if (c_r.ch >= 3'(NUM_BURST_CH)) begin
               c_nxt.st = C_IDLE;
            end else if (ch_en_i[c_r.ch[1:0]] && want != 5'h0 && room != 5'h0) begin
               c_nxt.cmd_addr  = ch_addr_i[c_r.ch[1:0]*7 +: 7];
               c_nxt.cmd_reg   = ch_reg_i[c_r.ch[1:0]*8 +: 8];
               c_nxt.cmd_rnw   = 1'b1;
               c_nxt.cmd_len   = (want > room) ? room : want;
               c_nxt.cmd_fifo  = ch_fifo_en_i[c_r.ch[1:0]];
               c_nxt.cmd_tgl   = ~c_r.cmd_tgl;
               c_nxt.st        = C_WAIT;
            end else begin
               c_nxt.ch = c_r.ch + 3'h1;
            end
         end
         C_WAIT: begin
            if (from_link_s[1] != c_r.ack_tgl) begin
               if (c_r.ch == SINGLE_CH) begin
                  c_nxt.ch4_rdata = l_r.rbyte;
                  c_nxt.ack_tgl = ~c_r.ack_tgl;
               end else if (!c_r.cmd_fifo || fifo_in_ready) begin
                  c_nxt.sens[c_r.idx*8 +: 8] = l_r.rbyte;
                  fifo_push = c_r.cmd_fifo;
                  c_nxt.idx = c_r.idx + 5'h1;
                  c_nxt.ack_tgl = ~c_r.ack_tgl;
               end
            end else if (from_link_s[0] != c_r.done_seen) begin
               c_nxt.done_seen = ~c_r.done_seen;
               if (c_r.ch == SINGLE_CH) begin
                  c_nxt.st = C_IDLE;
               end else begin
                  c_nxt.ch = c_r.ch + 3'h1;
                  c_nxt.st = l_r.arb ? C_IDLE : C_ISSUE;
               end
            end
         end
         default: begin
            c_nxt.st = C_IDLE;
         end
      endcase
      // Set wins over a clear arriving in the same cycle.
      if (flag_clr_i[0]) c_nxt.nack_f = 1'b0;
      if (flag_clr_i[1]) c_nxt.arb_f  = 1'b0;
      if (flag_clr_i[2]) c_nxt.ch4_f  = 1'b0;
      if (c_r.st == C_WAIT && from_link_s[0] != c_r.done_seen
          && from_link_s[1] == c_r.ack_tgl) begin
         if (l_r.nack) c_nxt.nack_f = 1'b1;
         if (l_r.arb) c_nxt.arb_f = 1'b1;
         if (c_r.ch == SINGLE_CH) c_nxt.ch4_f = 1'b1;
      end
      if (!rstn_i) begin
         c_nxt = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      c_r <= c_nxt;
   end

   // ---------------------------------------------------------------
   // Link engine: one bit is four quarter periods of the serial clock.
   // ---------------------------------------------------------------
   assign tick   = (l_r.tmr == 4'h0);
   assign tx_bit = (l_r.step != S_READ);

   always_comb begin
      l_nxt = l_r;
      if (l_r.st != L_IDLE && l_r.st != L_HSHK) begin
         l_nxt.tmr = tick ? (AUX_QUARTER_CYC - 4'h1) : (l_r.tmr - 4'h1);
         if (tick) l_nxt.q = l_r.q + 2'h1;
      end
      case (l_r.st)
         L_IDLE: begin
            l_nxt.scl_oe = 1'b0;
            l_nxt.sda_oe = 1'b0;
            l_nxt.q = 2'h0;
            l_nxt.tmr = AUX_QUARTER_CYC - 4'h1;
            if (to_link_s[2] != l_r.cmd_seen) begin
               l_nxt.cmd_seen = ~l_r.cmd_seen;
               l_nxt.addr = c_r.cmd_addr;
               l_nxt.regn = c_r.cmd_reg;
               l_nxt.rnw = c_r.cmd_rnw;
               l_nxt.left = c_r.cmd_len;
               l_nxt.wdata = c_r.cmd_wdata;
               l_nxt.nack = 1'b0;
               l_nxt.arb = 1'b0;
               l_nxt.st = L_START;
            end
         end
         L_START: if (tick) begin
            case (l_r.q)
               2'h1: l_nxt.sda_oe = 1'b1;
               2'h2: l_nxt.scl_oe = 1'b1;
               2'h3: begin
                  l_nxt.step = S_ADDR_W;
                  l_nxt.sh = {l_r.addr, 1'b0};
                  l_nxt.bitn = 3'h7;
                  l_nxt.st = L_BIT;
               end
               default: l_nxt.sda_oe = 1'b0;
            endcase
         end
         L_BIT: if (tick) begin
            case (l_r.q)
               2'h0: l_nxt.sda_oe = tx_bit && !l_r.sh[7];
               2'h1: l_nxt.scl_oe = 1'b0;
               2'h2: begin
                  l_nxt.sh = {l_r.sh[6:0], to_link_s[4]};
                  if (tx_bit && l_r.sh[7] && !to_link_s[4]) begin
                     l_nxt.arb = 1'b1;
                     l_nxt.sda_oe = 1'b0;
                     l_nxt.done_tgl = ~l_r.done_tgl;
                     l_nxt.st = L_IDLE;
                  end
               end
               default: begin
                  l_nxt.scl_oe = 1'b1;
                  l_nxt.bitn = l_r.bitn - 3'h1;
                  if (l_r.bitn == 3'h0) l_nxt.st = L_ACK;
               end
            endcase
         end
         L_ACK: if (tick) begin
            case (l_r.q)
               2'h0: l_nxt.sda_oe = !tx_bit && (l_r.left != 5'h1);
               2'h1: l_nxt.scl_oe = 1'b0;
               2'h2: if (tx_bit && to_link_s[4]) l_nxt.nack = 1'b1;
               default: begin
                  l_nxt.scl_oe = 1'b1;
                  l_nxt.sda_oe = 1'b0;
                  l_nxt.bitn = 3'h7;
                  if (l_r.nack) begin
                     l_nxt.st = L_STOP;
                  end else begin
                     case (l_r.step)
                        S_ADDR_W: begin
                           l_nxt.step = S_REG;
                           l_nxt.sh = l_r.regn;
                           l_nxt.st = L_BIT;
                        end
                        S_REG: begin
                           l_nxt.step = S_WDATA;
                           l_nxt.sh = l_r.wdata;
                           l_nxt.st = l_r.rnw ? L_RSTART : L_BIT;
                        end
                        S_ADDR_R: begin
                           l_nxt.step = S_READ;
                           l_nxt.st = L_BIT;
                        end
                        S_READ: begin
                           l_nxt.rbyte = l_r.sh;
                           l_nxt.req_tgl = ~l_r.req_tgl;
                           l_nxt.st = L_HSHK;
                        end
                        default: l_nxt.st = L_STOP;
                     endcase
                  end
               end
            endcase
         end
         L_RSTART: if (tick) begin
            case (l_r.q)
               2'h1: l_nxt.scl_oe = 1'b0;
               2'h2: l_nxt.sda_oe = 1'b1;
               2'h3: begin
                  l_nxt.scl_oe = 1'b1;
                  l_nxt.step = S_ADDR_R;
                  l_nxt.sh = {l_r.addr, 1'b1};
                  l_nxt.st = L_BIT;
               end
               default: l_nxt.sda_oe = 1'b0;
            endcase
         end
         L_HSHK: begin
            // The serial clock is held low until the core takes the byte.
            if (to_link_s[1] == l_r.req_tgl) begin
               l_nxt.left = l_r.left - 5'h1;
               l_nxt.bitn = 3'h7;
               l_nxt.st = (l_r.left == 5'h1) ? L_STOP : L_BIT;
            end
         end
         L_STOP: if (tick) begin
            case (l_r.q)
               2'h1: l_nxt.scl_oe = 1'b0;
               2'h2: l_nxt.sda_oe = 1'b0;
               2'h3: begin
                  l_nxt.done_tgl = ~l_r.done_tgl;
                  l_nxt.st = L_IDLE;
               end
               default: l_nxt.sda_oe = 1'b1;
            endcase
         end
         default: l_nxt.st = L_IDLE;
      endcase
      if (!link_rstn) begin
         l_nxt = '0;
      end
   end

   always_ff @(posedge aux_link_clk_i) begin
      l_r <= l_nxt;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign host_target_addr_o    = {HOST_ADDR_HI, c_r.ad0};
   assign bypass_switch_en_o    = pass_through_i && !spi_select_i;
   assign ext_sens_data_o       = c_r.sens;
   assign ch4_rdata_o           = c_r.ch4_rdata;
   assign nack_flag_o           = c_r.nack_f;
   assign arb_lost_flag_o       = c_r.arb_f;
   assign ch4_done_flag_o       = c_r.ch4_f;
   assign busy_o                = (c_r.st != C_IDLE);
   assign aux_serial_clock_o    = 1'b0;
   assign aux_serial_data_o     = 1'b0;
   assign aux_serial_clock_oe_o = l_r.scl_oe && !to_link_s[0];
   assign aux_serial_data_oe_o  = l_r.sda_oe && !to_link_s[0];
endmodule

// ### verification/aux_sensor_bus_master_sva.sv
// Assertions on the ports of the auxiliary sensor bus master.
`timescale 1ns/100ps
module aux_master_chk
   import aux_bus_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rstn_i,
   input wire logic        address_select_pin_i,
   input wire logic        spi_select_i,
   input wire logic        pass_through_i,
   input wire logic        master_en_i,
   input wire logic        sample_tick_i,
   input wire logic [3:0]  ch_en_i,
   input wire logic [15:0] ch_len_i,
   input wire logic        ch4_start_i,
   input wire logic [2:0]  flag_clr_i,
   input wire logic [6:0]  host_target_addr_o,
   input wire logic        bypass_switch_en_o,
   input wire logic        nack_flag_o,
   input wire logic        ch4_done_flag_o,
   input wire logic        busy_o,
   input wire logic [7:0]  fifo_data_o,
   input wire logic        fifo_valid_o,
   input wire logic        fifo_ready_i,
   input wire logic        aux_serial_clock_oe_o,
   input wire logic        aux_serial_data_oe_o
);
   logic [4:0] pt_r;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // Counts core cycles spent in pass-through.
   always_ff @(posedge core_clk_i)
      if (!rstn_i || !pass_through_i) pt_r <= 5'h0;
      else if (pt_r != 5'h1f) pt_r <= pt_r + 5'h1;
   chk_addr_high: assert property ($past(rstn_i) |->
      host_target_addr_o[6:1] == HOST_ADDR_HI) else $error("address high bits wrong");
   chk_addr_low: assert property ($stable(address_select_pin_i) [*5] |->
      host_target_addr_o[0] == address_select_pin_i) else $error("address low bit stale");
   chk_bypass_sw: assert property (
      bypass_switch_en_o == (pass_through_i && !spi_select_i)) else $error("switch wrong");
   chk_pass_quiet: assert property (pt_r >= 5'h14 |->
      !aux_serial_clock_oe_o && !aux_serial_data_oe_o) else $error("lines driven in bypass");
   chk_tick_busy: assert property (sample_tick_i && master_en_i && !pass_through_i
      && !busy_o && ch_en_i[0] && ch_len_i[3:0] != 4'h0 |-> ##[1:2] busy_o)
      else $error("round not started");
   chk_tick_refused: assert property ((!busy_o && !sample_tick_i && !ch4_start_i) [*3]
      ##1 (!ch4_start_i && (pass_through_i || !master_en_i)) |=> !busy_o)
      else $error("refused tick started a round");
   chk_nack_sticky: assert property (nack_flag_o && !flag_clr_i[0] |=> nack_flag_o)
      else $error("nack flag lost");
   chk_nack_cause: assert property ($rose(nack_flag_o) |-> $past(busy_o))
      else $error("nack flag without transfer");
   chk_done_sticky: assert property (ch4_done_flag_o && !flag_clr_i[2] |=>
      ch4_done_flag_o) else $error("done flag lost");
   chk_fifo_hold: assert property (fifo_valid_o && !fifo_ready_i |=>
      fifo_valid_o && $stable(fifo_data_o)) else $error("fifo output not held");
endmodule
bind aux_sensor_bus_master aux_master_chk chk (.*);

// ### verification/aux_sensor_model.sv
// Behavioural sensor on the auxiliary two-wire bus.
`timescale 1ns/100ps
module aux_sensor_model #(
   parameter logic [6:0] ADDR = 7'h1e
) (
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic nack_i,
   output logic      sda_oe_o = 1'b0
);
   int         bitn = 9;
   logic       rd = 0, act = 0, first = 0;
   logic [7:0] sh, tx;
   // Start and repeated start restart the framing; stop ends the transfer.
   always @(negedge sda_i) if (scl_i) begin
      bitn = 0; first = 1; act = 0; rd = 0; tx = 8'hc3;
   end
   always @(posedge sda_i) if (scl_i) act = 0;
   always @(posedge scl_i) begin
      if (bitn < 8) sh = {sh[6:0], sda_i};
      else if (rd && sda_i) act = 0;
      bitn = bitn + 1;
   end
   // Read bytes are released after the last bit so that the master acknowledges.
   always @(negedge scl_i) begin
      if (bitn == 8) begin
         if (first) {act, rd} = {sh[7:1] == ADDR && !nack_i, sh[0]};
         sda_oe_o = act && (first || !rd);
      end else if (bitn == 9) begin
         bitn = 0;
         if (rd && !first) tx = tx + 8'h11;
         first = 0;
         sda_oe_o = rd && act && !tx[7];
      end else sda_oe_o = rd && act && !tx[7-bitn];
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the auxiliary sensor bus master.
`timescale 1ns/100ps
module testbench
   import aux_bus_pkg::*;
;
   logic core_clk_i = 0, aux_link_clk_i = 0, rstn_i, address_select_pin_i, spi_select_i;
   logic pass_through_i, master_en_i, sample_tick_i, ch4_start_i, ch4_rnw_i, fifo_ready_i;
   logic [3:0] ch_en_i, ch_fifo_en_i;
   logic [27:0] ch_addr_i;
   logic [31:0] ch_reg_i;
   logic [15:0] ch_len_i;
   logic [6:0] ch4_addr_i, host_target_addr_o;
   logic [7:0] ch4_reg_i, ch4_wdata_i, ch4_rdata_o, fifo_data_o;
   logic [2:0] flag_clr_i;
   logic [191:0] ext_sens_data_o;
   logic bypass_switch_en_o, nack_flag_o, arb_lost_flag_o, ch4_done_flag_o, busy_o;
   logic fifo_valid_o, aux_serial_clock_o, aux_serial_clock_oe_o, aux_serial_data_o;
   logic aux_serial_data_oe_o, sda_m, nack_m;
   wire  aux_serial_clock_i = !aux_serial_clock_oe_o;
   wire  aux_serial_data_i = !(aux_serial_data_oe_o || sda_m);
   int   err_count = 0, checked = 0;
   always #20 core_clk_i = ~core_clk_i;
   initial begin
      #7;
      forever #62.5 aux_link_clk_i = ~aux_link_clk_i;
   end
   aux_sensor_bus_master uut (.*);
   aux_sensor_model sens (.scl_i(aux_serial_clock_i), .sda_i(aux_serial_data_i),
                          .nack_i(nack_m), .sda_oe_o(sda_m));
   task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask
   task automatic wait_idle;
      tk(4);
      for (int i = 0; i < 20000 && busy_o !== 1'b0; i++) tk(1);
      if (busy_o !== 1'b0) begin
         err_count++;
         close_out;
      end
   endtask
   task automatic t_addr;
      address_select_pin_i = 1;
      tk(6);
      chk(host_target_addr_o, {HOST_ADDR_HI, 1'b1});
      pass_through_i = 1;
      tk(1);
      chk(bypass_switch_en_o, 1'b1);
      spi_select_i = 1;
      sample_tick_i = 1;
      tk(1);
      sample_tick_i = 0;
      chk(bypass_switch_en_o, 1'b0);
      tk(30);
      chk({busy_o, aux_serial_clock_oe_o, aux_serial_data_oe_o}, 3'h0);
      {pass_through_i, spi_select_i} = 2'h0;
      tk(20);
   endtask
   task automatic t_round;
      {ch_en_i, ch_fifo_en_i, ch_len_i} = {4'h3, 4'h1, 16'h0023};
      sample_tick_i = 1;
      tk(1);
      sample_tick_i = 0;
      wait_idle;
      for (int k = 0; k < 5; k++)
         chk(ext_sens_data_o[8*k +: 8], 8'hc3 + 8'h11 * (k % 3));
      for (int k = 0; k < 3; k++) begin
         chk({fifo_valid_o, fifo_data_o}, {1'b1, 8'(8'hc3 + 8'h11 * k)});
         fifo_ready_i = 1;
         tk(1);
         fifo_ready_i = 0;
         tk(1);
      end
      chk({fifo_valid_o, nack_flag_o}, 2'h0);
   endtask
   task automatic t_ch4(input logic rnw, input logic nk);
      {nack_m, ch4_rnw_i, ch4_start_i} = {nk, rnw, 1'b1};
      tk(1);
      ch4_start_i = 0;
      wait_idle;
      chk({nack_flag_o, arb_lost_flag_o}, {nk, 1'b0});
      if (!nk) chk(ch4_done_flag_o, 1'b1);
      if (rnw && !nk) chk(ch4_rdata_o, 8'hc3);
      flag_clr_i = 3'h7;
      tk(1);
      flag_clr_i = 3'h0;
      tk(1);
      chk({nack_flag_o, arb_lost_flag_o, ch4_done_flag_o}, 3'h0);
   endtask
   initial begin
      {rstn_i, address_select_pin_i, spi_select_i, pass_through_i, sample_tick_i} = 5'h0;
      {ch4_start_i, ch4_rnw_i, fifo_ready_i, nack_m, flag_clr_i} = 7'h0;
      {master_en_i, ch_en_i, ch_fifo_en_i, ch_len_i} = 25'h1000000;
      {ch_addr_i, ch_reg_i, ch4_addr_i} = {{4{7'h1e}}, 32'h03020100, 7'h1e};
      {ch4_reg_i, ch4_wdata_i} = 16'h0a5a;
      tk(20);
      rstn_i = 1;
      tk(4);
      t_addr;
      t_round;
      t_ch4(0, 0);
      t_ch4(1, 0);
      t_ch4(1, 1);
      close_out;
   end
endmodule
